// ### shared/ovfr_pkg.sv
// package for the output overvoltage fault response block
// assumes a 40 MHz core clock; shared by the handler and its timer
package ovfr_pkg;
  localparam int          CLK_HZ          = 40_000_000;
  localparam int          DEGLITCH_US     = 10;                          // one deglitch unit in us
  localparam int          DEGLITCH_CYC    = (DEGLITCH_US * CLK_HZ) / 1_000_000;
  localparam int          MS_CYC          = CLK_HZ / 1000;               // cycles per millisecond
  localparam logic [7:0]  CMD_OV_RESP     = 8'h41;                       // command code of the response byte
  localparam logic [7:0]  OV_RESP_RST     = 8'hb8;                       // default response byte
  localparam logic [7:0]  CODE_LATCH      = 8'h80;                       // immediate, no retry
  localparam logic [7:0]  CODE_RETRY      = 8'hb8;                       // immediate, retry forever
  localparam logic [4:0]  CODE_DLY_LATCH  = 5'h08;                       // upper bits of 0x4n
  localparam logic [4:0]  CODE_DLY_RETRY  = 5'h0f;                       // upper bits of 0x78+n
  localparam int          RESP_HI         = 7;
  localparam int          RESP_LO         = 6;
  localparam int          RETRY_HI        = 5;
  localparam int          RETRY_LO        = 3;
  localparam int          DELAY_HI        = 2;
  localparam logic [1:0]  RESP_PULLDOWN   = 2'b00;
  localparam logic [1:0]  RESP_DELAYED    = 2'b01;
  localparam logic [1:0]  RESP_IMMEDIATE  = 2'b10;
  localparam logic [2:0]  RETRY_FOREVER   = 3'b111;
  localparam logic [16:0] RETRY_MS_MIN    = 17'd120;                     // shortest retry interval
  localparam logic [16:0] RETRY_MS_MAX    = 17'd83880;                   // longest retry interval
  localparam logic [16:0] RETRY_MS_RST    = 17'd350;                     // default retry interval
  typedef enum logic [2:0] {OVFR_RUN, OVFR_DEGLITCH, OVFR_OFF_LATCHED, OVFR_OFF_RETRY, OVFR_RESTART} ovfr_state_t;
endpackage : ovfr_pkg

// ### rtl/ovfr_timer.sv
// down-counting interval timer in units of a fixed number of clock cycles
// assumes load and run come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module ovfr_timer #(
  parameter int UNIT_CYC = 400,
  parameter int CNT_W    = 17
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] units,
  input  wire logic             run,
  output var  logic             done
);
  import ovfr_pkg::*;
  logic [31:0]      pre_ff;
  logic [CNT_W-1:0] cnt_ff;

  // prescaler and unit counter; done is a level once the count runs out
  always_ff @(posedge clk) begin
    if (srst || load) begin
      pre_ff <= 32'h0;
      cnt_ff <= srst ? '0 : units;
    end else if (run && cnt_ff != '0) begin
      if (pre_ff == 32'(UNIT_CYC - 1)) begin
        pre_ff <= 32'h0;
        cnt_ff <= cnt_ff - CNT_W'(1);
      end else begin
        pre_ff <= pre_ff + 32'h1;
      end
    end
  end

  assign done = run && !load && cnt_ff == '0;
endmodule : ovfr_timer
`default_nettype wire

// ### rtl/ovfr_handler.sv
// output overvoltage fault response handler for one channel
// assumes a command decoder on clk delivers byte writes; ov comparator and run pin are asynchronous
// Operation
// - on fault set summary ov bit, status word vout bit, vout ov bit
// - on fault raise alert unless masked
// - accept only 0x80, 0xb8, 0x4n, 0x78+n; else cml fault, value kept
// - 0x80 disables output at once, no retry
// - 0xb8 disables output and retries until off, bias loss or other fault
// - 0x4n shuts down after deglitch, stays off until off-on cycle, clear-faults or reset
// - 0x78+n shuts down after deglitch and retries until off, bias loss or other fault
// - deglitched codes act only if fault persists n times 10 us
// - response 00 only pulls output down while over limit; never set, as writes of it are refused
// - delayed response keeps running for bits 2:0 then follows retry field
// - immediate response disables output then follows retry field
// - unsupported response field raises cml fault
// - retry field 000-110 never restarts after fault shutdown
// - retry field 111 restarts forever spaced by retry interval
// - delay field counts 10 us units of continued operation
// - fault bit clears only on clear-faults, off-then-on, or bias cycle
// - response setting is one byte written and read back
// - response setting sits at command 0x41, default 0xb8
// - retry interval 120 ms to 83.88 s in 1 ms steps
`timescale 1ns/1ps
`default_nettype none
module ovfr_handler #(
  parameter int RETRY_UNIT_CYC = ovfr_pkg::MS_CYC
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        cmd_wr,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [7:0]  cmd_data,
  input  wire logic [7:0]  cmd_rd_code,
  output logic      [7:0]  cmd_rd_data,
  input  wire logic [16:0] retry_interval_setting,
  input  wire logic        clear_faults,
  input  wire logic        other_fault_noretry,
  input  wire logic        operation_on,
  input  wire logic        run_pin,
  input  wire logic        ov_detect,
  input  wire logic        alert_mask,
  output logic             out_enable,
  output logic             ov_pull_down,
  output logic             restart_req,
  output logic             status_byte_ov,
  output logic             status_word_vout,
  output logic             status_vout_ov,
  output logic             alert_n,
  output logic             cml_fault
);
  import ovfr_pkg::*;

  logic [7:0]  resp_ff;
  logic [1:0]  ov_sync_ff;
  logic [1:0]  run_sync_ff;
  logic        on_ff;
  logic        ov_flag_ff;
  logic        cml_ff;
  logic        pd_ff;
  logic        oe_ff;
  logic        rst_req_ff;
  logic        alert_n_ff;
  logic [7:0]  rd_ff;
  ovfr_state_t state_ff;
  ovfr_state_t nxt_state;
  logic        ov_s;
  logic        on_now;
  logic        off_on;
  logic        commanded_off;
  logic        deg_done;
  logic        retry_done;
  logic        shutdown_evt;
  logic        fault_evt;
  logic [16:0] retry_units;

  // true when a written byte is one of the recognised response codes
  function automatic logic code_ok(input logic [7:0] v);
    code_ok = (v == CODE_LATCH) || (v == CODE_RETRY) ||
              (v[7:3] == CODE_DLY_LATCH) || (v[7:3] == CODE_DLY_RETRY);
  endfunction : code_ok

  // clamp the retry interval into its legal range
  function automatic logic [16:0] clamp_ms(input logic [16:0] v);
    if (v < RETRY_MS_MIN) clamp_ms = RETRY_MS_MIN;
    else if (v > RETRY_MS_MAX) clamp_ms = RETRY_MS_MAX;
    else clamp_ms = v;
  endfunction : clamp_ms

  // two-stage synchronisers for the comparator and run pin
  // run stage resets to the on level so release of reset shows no false off-then-on
  always_ff @(posedge clk) begin
    if (srst) begin
      ov_sync_ff  <= 2'b00;
      run_sync_ff <= 2'b11;
    end else begin
      ov_sync_ff  <= {ov_sync_ff[0], ov_detect};
      run_sync_ff <= {run_sync_ff[0], run_pin};
    end
  end
  assign ov_s   = ov_sync_ff[1];
  assign on_now = run_sync_ff[1] && operation_on;

  // track the combined on command to spot an off-then-on cycle
  always_ff @(posedge clk) begin
    if (srst) on_ff <= 1'b1;
    else on_ff <= on_now;
  end
  assign off_on        = on_now && !on_ff;
  assign commanded_off = !on_now;

  // response byte register with write filtering
  always_ff @(posedge clk) begin
    if (srst) begin
      resp_ff <= OV_RESP_RST;
    end else if (cmd_wr && cmd_code == CMD_OV_RESP && code_ok(cmd_data)) begin
      resp_ff <= cmd_data;
    end
  end

  // communication fault on an unsupported value; write ignored
  always_ff @(posedge clk) begin
    if (srst) cml_ff <= 1'b0;
    else if (cmd_wr && cmd_code == CMD_OV_RESP && !code_ok(cmd_data)) cml_ff <= 1'b1;
    else if (clear_faults) cml_ff <= 1'b0;
  end

  // read-back of the response byte
  always_ff @(posedge clk) begin
    if (srst) rd_ff <= 8'h00;
    else rd_ff <= (cmd_rd_code == CMD_OV_RESP) ? resp_ff : 8'h00;
  end

  // deglitch timer: counts bits 2:0 in 10 us units
  ovfr_timer #(.UNIT_CYC(DEGLITCH_CYC), .CNT_W(17)) u_deglitch (
    .clk   (clk),
    .srst  (srst),
    .load  (state_ff == OVFR_RUN),
    .units ({14'h0, resp_ff[DELAY_HI:0]}),
    .run   (state_ff == OVFR_DEGLITCH),
    .done  (deg_done)
  );

  // retry timer in 1 ms units
  assign retry_units = clamp_ms(retry_interval_setting);
  ovfr_timer #(.UNIT_CYC(RETRY_UNIT_CYC), .CNT_W(17)) u_retry (
    .clk   (clk),
    .srst  (srst),
    .load  (state_ff != OVFR_OFF_RETRY),
    .units (retry_units),
    .run   (state_ff == OVFR_OFF_RETRY),
    .done  (retry_done)
  );

  // fault detection event: any overvoltage seen while running
  assign fault_evt    = ov_s && state_ff == OVFR_RUN;
  assign shutdown_evt = (state_ff == OVFR_DEGLITCH && ov_s && deg_done) ||
                        (state_ff == OVFR_RUN && ov_s && resp_ff[RESP_HI:RESP_LO] == RESP_IMMEDIATE);

  // response sequencing
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      OVFR_RUN: begin
        if (ov_s && resp_ff[RESP_HI:RESP_LO] == RESP_DELAYED) nxt_state = OVFR_DEGLITCH;
        else if (shutdown_evt) nxt_state = (resp_ff[RETRY_HI:RETRY_LO] == RETRY_FOREVER) ?
                                           OVFR_OFF_RETRY : OVFR_OFF_LATCHED;
      end
      OVFR_DEGLITCH: begin
        if (!ov_s) nxt_state = OVFR_RUN;
        else if (deg_done) nxt_state = (resp_ff[RETRY_HI:RETRY_LO] == RETRY_FOREVER) ?
                                       OVFR_OFF_RETRY : OVFR_OFF_LATCHED;
      end
      OVFR_OFF_LATCHED: begin
        if (off_on || clear_faults) nxt_state = OVFR_RUN;
      end
      OVFR_OFF_RETRY: begin
        if (other_fault_noretry) nxt_state = OVFR_OFF_LATCHED;
        else if (commanded_off) nxt_state = OVFR_OFF_LATCHED;
        else if (retry_done) nxt_state = OVFR_RESTART;
      end
      OVFR_RESTART: nxt_state = OVFR_RUN;
      default: nxt_state = OVFR_RUN;
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) state_ff <= OVFR_RUN;
    else state_ff <= nxt_state;
  end

  // output drive and restart pulse
  always_ff @(posedge clk) begin
    if (srst) begin
      oe_ff      <= 1'b1;
      rst_req_ff <= 1'b0;
    end else begin
      oe_ff      <= (nxt_state == OVFR_RUN) || (nxt_state == OVFR_DEGLITCH) || (nxt_state == OVFR_RESTART);
      rst_req_ff <= (nxt_state == OVFR_RESTART);
    end
  end

  // pull-down only mode while over the limit
  always_ff @(posedge clk) begin
    if (srst) pd_ff <= 1'b0;
    else pd_ff <= ov_s && resp_ff[RESP_HI:RESP_LO] == RESP_PULLDOWN;
  end

  // sticky overvoltage status, set wins over clear
  always_ff @(posedge clk) begin
    if (srst) ov_flag_ff <= 1'b0;
    else if (fault_evt) ov_flag_ff <= 1'b1;
    else if (clear_faults || off_on) ov_flag_ff <= 1'b0;
  end

  // alert line follows the status unless masked
  always_ff @(posedge clk) begin
    if (srst) alert_n_ff <= 1'b1;
    else alert_n_ff <= !((ov_flag_ff || fault_evt) && !alert_mask);
  end

  assign out_enable       = oe_ff;
  assign ov_pull_down     = pd_ff;
  assign restart_req      = rst_req_ff;
  assign status_byte_ov   = ov_flag_ff;
  assign status_word_vout = ov_flag_ff;
  assign status_vout_ov   = ov_flag_ff;
  assign alert_n          = alert_n_ff;
  assign cml_fault        = cml_ff;
  assign cmd_rd_data      = rd_ff;

  // assertions
  property p_bad_write_kept;
    @(posedge clk) disable iff (srst)
      (cmd_wr && cmd_code == CMD_OV_RESP && !code_ok(cmd_data)) |=> (cml_fault && $stable(resp_ff));
  endproperty
  a_bad_write_kept: assert property (p_bad_write_kept) else $error("bad code not rejected");

  property p_latch_off;
    @(posedge clk) disable iff (srst)
      (state_ff == OVFR_RUN && ov_s && resp_ff == CODE_LATCH) |=> !out_enable ##1 !out_enable;
  endproperty
  a_latch_off: assert property (p_latch_off) else $error("0x80 did not disable");

  property p_status_set;
    @(posedge clk) disable iff (srst)
      fault_evt |=> (status_byte_ov && status_word_vout && status_vout_ov);
  endproperty
  a_status_set: assert property (p_status_set) else $error("status bits not set");

  property p_alert;
    @(posedge clk) disable iff (srst)
      (fault_evt && !alert_mask) |=> !alert_n;
  endproperty
  a_alert: assert property (p_alert) else $error("alert not raised");

  property p_flag_sticky;
    @(posedge clk) disable iff (srst)
      (status_vout_ov && !clear_faults && !off_on) |=> status_vout_ov;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("fault bit cleared early");

  property p_pulldown;
    @(posedge clk) disable iff (srst)
      (ov_s && resp_ff[7:6] == 2'b00) |=> (ov_pull_down && state_ff == OVFR_RUN);
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pull-down mode wrong");

  property p_no_restart_latched;
    @(posedge clk) disable iff (srst)
      (state_ff == OVFR_OFF_LATCHED) |-> !restart_req;
  endproperty
  a_no_restart_latched: assert property (p_no_restart_latched) else $error("restart without retry");

  property p_deglitch_min;
    @(posedge clk) disable iff (srst)
      ($rose(state_ff == OVFR_DEGLITCH) && resp_ff[2:0] != 3'b000) |-> out_enable [*8];
  endproperty
  a_deglitch_min: assert property (p_deglitch_min) else $error("shut down before deglitch");

  property p_restart_on;
    @(posedge clk) disable iff (srst)
      restart_req |-> (out_enable ##1 state_ff == OVFR_RUN);
  endproperty
  a_restart_on: assert property (p_restart_on) else $error("restart not started");

  c_latch:    cover property (@(posedge clk) state_ff == OVFR_OFF_LATCHED);
  c_retry:    cover property (@(posedge clk) restart_req);
  c_deglitch: cover property (@(posedge clk) state_ff == OVFR_DEGLITCH ##1 state_ff == OVFR_RUN);
  c_cml:      cover property (@(posedge clk) $rose(cml_fault));
endmodule : ovfr_handler
`default_nettype wire

// ### testbench/ovfr_host_model.sv
// host model: single-byte writes and readbacks of the response byte
// assumes the handler samples commands on the rising edge of clk
`timescale 1ns/1ps
`default_nettype none
module ovfr_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] cmd_rd_data,
  output var  logic       cmd_wr,
  output var  logic [7:0] cmd_code,
  output var  logic [7:0] cmd_data,
  output var  logic [7:0] cmd_rd_code
);
  import ovfr_pkg::*;
  // idle bus at time zero
  initial begin
    cmd_wr      = 1'b0;
    cmd_code    = 8'h00;
    cmd_data    = 8'h00;
    cmd_rd_code = 8'h00;
  end
  // one data byte to the response command, held for one edge
  task automatic wr_byte(input logic [7:0] d);
    @(posedge clk);
    #2;
    cmd_wr   = 1'b1;
    cmd_code = CMD_OV_RESP;
    cmd_data = d;
    @(posedge clk);
    #2;
    cmd_wr   = 1'b0;
    cmd_code = 8'h00;
    cmd_data = ~d; // released data shows no stale value
  endtask : wr_byte
  // read back the response byte, one registered cycle later
  task automatic rd_byte(output logic [7:0] d);
    @(posedge clk);
    #2;
    cmd_rd_code = CMD_OV_RESP;
    @(posedge clk);
    #2;
    d           = cmd_rd_data;
    cmd_rd_code = 8'h00;
  endtask : rd_byte
endmodule : ovfr_host_model
`default_nettype wire

// ### testbench/output_overvoltage_fault_response_tb_top.sv
// testbench for the overvoltage response handler
// assumes a 40 MHz clock and a shortened retry unit of 4 cycles
`timescale 1ns/1ps
`default_nettype none
module output_overvoltage_fault_response_tb_top;
  import ovfr_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        cmd_wr;
  logic [7:0]  cmd_code, cmd_data, cmd_rd_code, cmd_rd_data, rd;
  logic [16:0] retry_interval_setting = 17'd50;
  logic        clear_faults = 1'b0, other_fault_noretry = 1'b0;
  logic        operation_on = 1'b1, run_pin = 1'b1, ov_detect = 1'b0, alert_mask = 1'b0;
  logic        out_enable, ov_pull_down, restart_req, st_byte, st_word, st_vout, alert_n, cml_fault;
  int          n_errors = 0;
  int          n_tests = 0;
  int          gap;
  logic [7:0]  last;
  // rows: {accepted, written byte}
  logic [8:0]  rows [10] = '{9'h180, 9'h1b8, 9'h140, 9'h147, 9'h178, 9'h17f, 9'h0c0, 9'h000, 9'h048, 9'h141};
  ovfr_host_model host (.clk(clk), .cmd_rd_data(cmd_rd_data), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
    .cmd_data(cmd_data), .cmd_rd_code(cmd_rd_code));
  ovfr_handler #(.RETRY_UNIT_CYC(4)) uut (.clk(clk), .srst(srst), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
    .cmd_data(cmd_data), .cmd_rd_code(cmd_rd_code), .cmd_rd_data(cmd_rd_data),
    .retry_interval_setting(retry_interval_setting), .clear_faults(clear_faults),
    .other_fault_noretry(other_fault_noretry), .operation_on(operation_on), .run_pin(run_pin),
    .ov_detect(ov_detect), .alert_mask(alert_mask), .out_enable(out_enable), .ov_pull_down(ov_pull_down),
    .restart_req(restart_req), .status_byte_ov(st_byte), .status_word_vout(st_word),
    .status_vout_ov(st_vout), .alert_n(alert_n), .cml_fault(cml_fault));
  // clock
  always #12.5 clk = ~clk;
  task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : cyc
  task automatic pulse_clear;
    clear_faults = 1'b1;
    cyc(1);
    clear_faults = 1'b0;
    cyc(3);
  endtask : pulse_clear
  // cycles until the next restart request, bounded
  task automatic wait_restart(output int n);
    n = 0;
    while (restart_req !== 1'b1 && n < 1000) begin
      cyc(1);
      n++;
    end
    if (n >= 1000) n_errors++; // limit ran out
  endtask : wait_restart
  task automatic results;
    if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  // watchdog
  initial begin
    #(20000 * 25);
    n_errors++;
    results();
  end
  initial begin
    cyc(4);
    srst = 1'b0;
    cyc(1);
    chk("out_enable", out_enable, 1);
    chk("alert_n", alert_n, 1);
    chk("status", {st_byte, st_word, st_vout, cml_fault, ov_pull_down}, 0);
    host.rd_byte(rd);
    chk("default", rd, OV_RESP_RST);
    // accepted and refused codes
    last = OV_RESP_RST;
    for (int i = 0; i < 10; i++) begin
      pulse_clear();
      host.wr_byte(rows[i][7:0]);
      if (rows[i][8]) last = rows[i][7:0];
      cyc(1);
      chk("cml", cml_fault, {7'h0, ~rows[i][8]});
      host.rd_byte(rd);
      chk("readback", rd, last);
    end
    // immediate latch-off
    pulse_clear();
    host.wr_byte(8'h80);
    ov_detect = 1'b1;
    cyc(4);
    chk("out_enable", out_enable, 0);
    chk("flags", {st_byte, st_word, st_vout, alert_n}, 8'h0e);
    ov_detect = 1'b0;
    cyc(600);
    chk("out_enable", out_enable, 0);
    chk("sticky", st_vout, 1);
    pulse_clear();
    chk("cleared", {st_byte, st_vout, out_enable}, 8'h01);
    // immediate retry, alert masked, interval clamped to 120 units
    alert_mask = 1'b1;
    host.wr_byte(8'hb8);
    ov_detect = 1'b1;
    cyc(4);
    chk("masked", {alert_n, st_word, out_enable}, 8'h06);
    ov_detect = 1'b0;
    wait_restart(gap);
    chk("retry gap", (gap >= 460 && gap <= 490), 1);
    cyc(1);
    chk("restarted", out_enable, 1);
    alert_mask = 1'b0;
    // retry stopped by a no-retry fault
    ov_detect = 1'b1;
    cyc(4);
    other_fault_noretry = 1'b1;
    cyc(1);
    other_fault_noretry = 1'b0;
    ov_detect = 1'b0;
    cyc(700);
    chk("no retry", out_enable, 0);
    operation_on = 1'b0;
    cyc(4);
    operation_on = 1'b1;
    cyc(4);
    chk("off on", {out_enable, st_vout}, 8'h02);
    // deglitched latch-off, n = 1
    host.wr_byte(8'h41);
    ov_detect = 1'b1;
    cyc(200);
    ov_detect = 1'b0;
    cyc(10);
    chk("glitch", out_enable, 1);
    ov_detect = 1'b1;
    cyc(300);
    chk("running", out_enable, 1);
    cyc(110);
    chk("deglitched", out_enable, 0);
    ov_detect = 1'b0;
    cyc(600);
    chk("stays off", out_enable, 0);
    run_pin = 1'b0;
    cyc(4);
    run_pin = 1'b1;
    cyc(6);
    chk("pin cycle", {out_enable, st_vout}, 8'h02);
    // deglitched retry, n = 2
    host.wr_byte(8'h7a);
    ov_detect = 1'b1;
    cyc(850);
    chk("deglitched", out_enable, 0);
    ov_detect = 1'b0;
    wait_restart(gap);
    chk("retried", restart_req, 1);
    results();
  end
endmodule : output_overvoltage_fault_response_tb_top
`default_nettype wire
